// ==== ccrb_host.sv ====
// Two-wire bus master standing in for the host controller.
`timescale 1ns/10ps
module ccrb_host (
    input wire logic mclk_i,
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o,
    output logic [7:0] rd_data_o,
    output logic rd_done_o
);
    logic drv = 1'b1;
    // The data line has a pull-up, so a released line reads high.
    assign sda_o = drv & ~sda_oe_i;
    initial begin
        scl_o = 1'b1;
        rd_done_o = 1'b0;
        rd_data_o = 8'h00;
    end
    // Six cycles a phase keeps clear of the two-flop synchroniser delay.
    task automatic put(input logic c, input logic d);
        repeat (6) @(negedge mclk_i);
        scl_o = c;
        drv = d;
    endtask
    task automatic start();
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            put(1'b0, tx[i]);
            put(1'b1, tx[i]);
            repeat (6) @(negedge mclk_i);
            rx[i] = sda_o;
            scl_o = 1'b0;
        end
    endtask
    // Reserved places are written only where the bench asks for it.
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [8:0] rx;
        start();
        xfer({ccrb_pkg::DEV_ADDR, 2'b01}, rx);
        xfer({ofs, 1'b1}, rx);
        xfer({d, 1'b1}, rx);
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask
    task automatic rd(input logic [7:0] ofs);
        logic [8:0] rx;
        start();
        xfer({ccrb_pkg::DEV_ADDR, 2'b01}, rx);
        xfer({ofs, 1'b1}, rx);
        start();
        xfer({ccrb_pkg::DEV_ADDR, 2'b11}, rx);
        xfer(9'h1ff, rx);
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        rd_data_o = rx[8:1];
        rd_done_o = 1'b1;
        @(negedge mclk_i);
        rd_done_o = 1'b0;
    endtask
endmodule // ccrb_host

// ==== ccrb_pkg.sv ====
// Shared constants, register map and carrier types of the control bank.
package ccrb_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int WD_TICK_CYCLES = CLK_HZ;
    localparam logic [8:0] WD_SEC_80 = 9'h050;
    localparam logic [8:0] WD_SEC_160 = 9'h0a0;
    localparam logic [8:0] WD_SEC_320 = 9'h140;
    localparam int AUDIO_FLOOR_HZ = 31250;
    localparam int OCP_TRIP_CYCLES = 8;

    localparam logic [6:0] DEV_ADDR = 7'h24;

    localparam logic [7:0] OFS_MAIN_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_MAIN_CONTROL_TWO = 8'h01;
    localparam logic [7:0] OFS_GENERAL_STATUS = 8'h02;
    localparam logic [7:0] OFS_THERMAL_STATUS = 8'h03;
    localparam logic [7:0] OFS_FAULT_ONE = 8'h05;
    localparam logic [7:0] OFS_OUTPUT_CURRENT_LIMIT = 8'h17;
    localparam logic [7:0] OFS_RESERVED_18 = 8'h18;
    localparam logic [7:0] OFS_RESERVED_19 = 8'h19;
    localparam logic [7:0] OFS_INPUT_UNDERVOLTAGE_LEVEL = 8'h1a;
    localparam logic [7:0] OFS_RESERVED_1B = 8'h1b;
    localparam logic [7:0] OFS_RESERVED_1C = 8'h1c;
    localparam logic [7:0] OFS_SWITCHING_FREQUENCY = 8'h1d;
    localparam logic [7:0] OFS_INTERRUPT_MASK_ONE = 8'h1e;
    localparam logic [7:0] OFS_INTERRUPT_MASK_TWO = 8'h1f;
    localparam logic [7:0] OFS_OUTPUT_CONVERTER_STATUS = 8'h20;

    localparam int BIT_FORCED_HIZ = 7;
    localparam int BIT_WD_KICK = 2;
    localparam int BIT_AUDIO_FLOOR = 1;
    localparam int BIT_RESTORE = 0;
    localparam int BIT_OCP_DISABLE = 6;
    localparam int BIT_PEAK_SELECT = 4;
    localparam int BIT_INT_RELEASE = 7;
    localparam int BIT_INT_LEVEL = 6;
    localparam int BIT_EN_LEVEL = 5;
    localparam int BIT_THERMAL = 6;

    localparam logic [1:0] MODE_HIZ = 2'h0;
    localparam logic [1:0] MODE_POWER_ON = 2'h2;

    localparam logic [7:0] RST_MAIN_CONTROL_TWO = 8'hb4;
    localparam logic [6:0] RST_OUTPUT_CURRENT_LIMIT = 7'h64;
    localparam logic [6:0] MAX_OUTPUT_CURRENT_LIMIT = 7'h64;
    localparam logic [7:0] RST_RESERVED_18 = 8'h64;
    localparam logic [7:0] RST_RESERVED_19 = 8'h00;
    localparam logic [7:0] RST_INPUT_UNDERVOLTAGE_LEVEL = 8'h00;
    localparam logic [7:0] RST_RESERVED_1B = 8'h40;
    localparam logic [7:0] RST_RESERVED_1C = 8'h40;
    localparam logic [7:0] RST_SWITCHING_FREQUENCY = 8'h83;
    localparam logic [7:0] RST_INTERRUPT_MASK = 8'h00;

    typedef struct packed {
        logic forced_hiz;
        logic audio_floor;
        logic [7:0] main_control_two;
        logic [6:0] output_current_limit;
        logic [7:0] input_undervoltage_level;
        logic [7:0] switching_frequency;
        logic [7:0] interrupt_mask_one;
        logic [7:0] interrupt_mask_two;
    } ccrb_cfg_s;

    localparam ccrb_cfg_s CFG_DEFAULT = '{
        forced_hiz: 1'b0,
        audio_floor: 1'b0,
        main_control_two: RST_MAIN_CONTROL_TWO,
        output_current_limit: RST_OUTPUT_CURRENT_LIMIT,
        input_undervoltage_level: RST_INPUT_UNDERVOLTAGE_LEVEL,
        switching_frequency: RST_SWITCHING_FREQUENCY,
        interrupt_mask_one: RST_INTERRUPT_MASK,
        interrupt_mask_two: RST_INTERRUPT_MASK
    };

endpackage

// ==== ccrb_top.sv ====
// Converter control register bank behind a serial two-wire slave port.
//
// Summary of operation
// - A set forced high-impedance bit keeps the converter off whatever the enable pin or override say.
// - The host writes the kick bit before the watchdog expires and the bit always reads back as zero.
// - The watchdog period field selects disabled, 80 s, 160 s or 320 s.
// - In the high-impedance state the watchdog is disabled and its count held at zero.
// - A disabled watchdog period also clears the watchdog count.
// - The audio frequency limit bit asks the converter for a 31.25 kHz switching floor.
// - Writing one to the restore-defaults bit returns every register to its default and it reads zero.
// - Unless shutdown is disabled, 8 consecutive current-limited switching cycles turn the converter off.
// - The peak current select bit picks 8.5 A when zero and 10 A when one, defaulting to one.
// - General status bit 5 shows the live level of the enable pin.
// - The system state field reads 00 in high impedance and 10 when powered on.
// - The output current limit holds a 7-bit percent code from 0 to 100, default 100.
// - The input undervoltage register holds an 8-bit code in 100 mV steps.
// - Writing one to the interrupt release bit frees the interrupt line unless a fault or an expired watchdog is present in that cycle, and the bit reads zero.
`timescale 1ns/10ps
module ccrb_top #(
    parameter int WD_TICK_CYCLES = ccrb_pkg::WD_TICK_CYCLES,
    parameter int OCP_CYCLES = ccrb_pkg::OCP_TRIP_CYCLES
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic enable_pin_i,
    input wire logic enable_override_i,
    input wire logic interrupt_line_i,
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe_o,
    input wire logic fault_event_i,
    input wire logic switch_cycle_i,
    input wire logic current_limit_trip_i,
    input wire logic thermal_active_i,
    input wire logic [7:0] output_converter_status_i,
    output ccrb_pkg::ccrb_cfg_s cfg_o,
    output logic powered_on_o,
    output logic overcurrent_off_o,
    output logic watchdog_expired_o
);
    typedef enum logic [2:0] {
        CCRB_IDLE, CCRB_ADDR, CCRB_AACK, CCRB_RX,
        CCRB_RACK, CCRB_TX, CCRB_TACK, CCRB_TLOAD
    } ccrb_i2c_e;

    // Pin synchronisers; the second stage is read, and for scl and sda a third stage feeds edge detect.
    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    logic en_s1_r, en_s2_r;
    logic irq_s1_r, irq_s2_r;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
            irq_s1_r <= 1'b1;
            irq_s2_r <= 1'b1;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
            en_s1_r <= enable_pin_i;
            en_s2_r <= en_s1_r;
            irq_s1_r <= interrupt_line_i;
            irq_s2_r <= irq_s1_r;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_s2_r && !scl_d_r;
    assign scl_fall = !scl_s2_r && scl_d_r;
    assign start_seen = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
    assign stop_seen = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

    // Register state.
    ccrb_pkg::ccrb_cfg_s cfg_r, cfg_nxt;
    logic kick_r, kick_nxt;
    logic irq_r, irq_nxt;
    logic powered_r, powered_nxt;
    logic ocp_off_r, ocp_off_nxt;
    logic [4:0] ocp_cnt_r, ocp_cnt_nxt;
    logic [7:0] rdata;
    logic [7:0] sh_ptr_r, sh_ptr_nxt;

    // Read mux; reserved slots read their defaults and hold no storage.
    always_comb begin
        rdata = 8'h00;
        case (sh_ptr_r)
            ccrb_pkg::OFS_MAIN_CONTROL_ONE: begin
                rdata[ccrb_pkg::BIT_FORCED_HIZ] = cfg_r.forced_hiz;
                rdata[ccrb_pkg::BIT_AUDIO_FLOOR] = cfg_r.audio_floor;
            end
            ccrb_pkg::OFS_MAIN_CONTROL_TWO: rdata = cfg_r.main_control_two;
            ccrb_pkg::OFS_GENERAL_STATUS: begin
                rdata[ccrb_pkg::BIT_INT_LEVEL] = irq_s2_r;
                rdata[ccrb_pkg::BIT_EN_LEVEL] = en_s2_r;
                rdata[1:0] = powered_r ? ccrb_pkg::MODE_POWER_ON
                                       : ccrb_pkg::MODE_HIZ;
            end
            ccrb_pkg::OFS_THERMAL_STATUS:
                rdata[ccrb_pkg::BIT_THERMAL] = thermal_active_i;
            ccrb_pkg::OFS_OUTPUT_CURRENT_LIMIT:
                rdata = {1'b0, cfg_r.output_current_limit};
            ccrb_pkg::OFS_RESERVED_18: rdata = ccrb_pkg::RST_RESERVED_18;
            ccrb_pkg::OFS_RESERVED_19: rdata = ccrb_pkg::RST_RESERVED_19;
            ccrb_pkg::OFS_INPUT_UNDERVOLTAGE_LEVEL:
                rdata = cfg_r.input_undervoltage_level;
            ccrb_pkg::OFS_RESERVED_1B: rdata = ccrb_pkg::RST_RESERVED_1B;
            ccrb_pkg::OFS_RESERVED_1C: rdata = ccrb_pkg::RST_RESERVED_1C;
            ccrb_pkg::OFS_SWITCHING_FREQUENCY:
                rdata = cfg_r.switching_frequency;
            ccrb_pkg::OFS_INTERRUPT_MASK_ONE:
                rdata = cfg_r.interrupt_mask_one;
            ccrb_pkg::OFS_INTERRUPT_MASK_TWO:
                rdata = cfg_r.interrupt_mask_two;
            ccrb_pkg::OFS_OUTPUT_CONVERTER_STATUS:
                rdata = output_converter_status_i;
            default: rdata = 8'h00;
        endcase
    end

    // Two-wire slave: register pointer first, then data with auto-increment.
    ccrb_i2c_e st_r, st_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic rw_r, rw_nxt;
    logic first_r, first_nxt;
    logic ackd_r, ackd_nxt;
    logic oe_r, oe_nxt;
    logic wr_r, wr_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;
    logic [7:0] sh_in;

    assign sh_in = {sh_r[6:0], sda_s2_r};

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        sh_ptr_nxt = sh_ptr_r;
        bit_nxt = bit_r;
        rw_nxt = rw_r;
        first_nxt = first_r;
        ackd_nxt = ackd_r;
        oe_nxt = oe_r;
        wr_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        if (start_seen) begin
            st_nxt = CCRB_ADDR;
            bit_nxt = 3'h0;
            first_nxt = 1'b1;
            oe_nxt = 1'b0;
        end else if (stop_seen) begin
            st_nxt = CCRB_IDLE;
            oe_nxt = 1'b0;
        end else begin
            case (st_r)
                CCRB_IDLE: oe_nxt = 1'b0;
                CCRB_ADDR: if (scl_rise) begin
                    sh_nxt = sh_in;
                    bit_nxt = bit_r + 3'h1;
                    if (bit_r == 3'h7) begin
                        rw_nxt = sda_s2_r;
                        ackd_nxt = 1'b0;
                        st_nxt = (sh_in[7:1] == ccrb_pkg::DEV_ADDR)
                                 ? CCRB_AACK : CCRB_IDLE;
                    end
                end
                CCRB_AACK, CCRB_RACK: if (scl_fall) begin
                    if (!ackd_r) begin
                        oe_nxt = 1'b1;
                        ackd_nxt = 1'b1;
                    end else begin
                        bit_nxt = 3'h0;
                        if (st_r == CCRB_AACK && rw_r) begin
                            sh_nxt = rdata;
                            oe_nxt = !rdata[7];
                            st_nxt = CCRB_TX;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = CCRB_RX;
                        end
                    end
                end
                CCRB_RX: if (scl_rise) begin
                    sh_nxt = sh_in;
                    bit_nxt = bit_r + 3'h1;
                    if (bit_r == 3'h7) begin
                        ackd_nxt = 1'b0;
                        st_nxt = CCRB_RACK;
                        if (first_r) begin
                            first_nxt = 1'b0;
                            sh_ptr_nxt = sh_in;
                        end else begin
                            wr_nxt = 1'b1;
                            wr_addr_nxt = sh_ptr_r;
                            wr_data_nxt = sh_in;
                            sh_ptr_nxt = sh_ptr_r + 8'h01;
                        end
                    end
                end
                CCRB_TX: if (scl_fall) begin
                    bit_nxt = bit_r + 3'h1;
                    if (bit_r == 3'h7) begin
                        oe_nxt = 1'b0;
                        st_nxt = CCRB_TACK;
                    end else begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        oe_nxt = !sh_r[6];
                    end
                end
                CCRB_TACK: if (scl_rise) begin
                    if (sda_s2_r) begin
                        st_nxt = CCRB_IDLE;
                    end else begin
                        sh_ptr_nxt = sh_ptr_r + 8'h01;
                        st_nxt = CCRB_TLOAD;
                    end
                end
                CCRB_TLOAD: if (scl_fall) begin
                    sh_nxt = rdata;
                    oe_nxt = !rdata[7];
                    bit_nxt = 3'h0;
                    st_nxt = CCRB_TX;
                end
                default: st_nxt = CCRB_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= CCRB_IDLE;
            sh_r <= 8'h00;
            sh_ptr_r <= 8'h00;
            bit_r <= 3'h0;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            ackd_r <= 1'b0;
            oe_r <= 1'b0;
            wr_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            sh_ptr_r <= sh_ptr_nxt;
            bit_r <= bit_nxt;
            rw_r <= rw_nxt;
            first_r <= first_nxt;
            ackd_r <= ackd_nxt;
            oe_r <= oe_nxt;
            wr_r <= wr_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    // Register writes and the block's own control state.
    logic wd_expired;
    logic ocp_disable;
    assign ocp_disable = cfg_r.main_control_two[ccrb_pkg::BIT_OCP_DISABLE];

    always_comb begin
        cfg_nxt = cfg_r;
        kick_nxt = 1'b0;
        irq_nxt = irq_r;
        ocp_cnt_nxt = ocp_cnt_r;
        ocp_off_nxt = ocp_off_r;
        // Status registers have no write path at all.
        if (wr_r) begin
            case (wr_addr_r)
                ccrb_pkg::OFS_MAIN_CONTROL_ONE: begin
                    if (wr_data_r[ccrb_pkg::BIT_RESTORE]) begin
                        cfg_nxt = ccrb_pkg::CFG_DEFAULT;
                    end else begin
                        cfg_nxt.forced_hiz =
                            wr_data_r[ccrb_pkg::BIT_FORCED_HIZ];
                        cfg_nxt.audio_floor =
                            wr_data_r[ccrb_pkg::BIT_AUDIO_FLOOR];
                        kick_nxt = wr_data_r[ccrb_pkg::BIT_WD_KICK];
                    end
                end
                ccrb_pkg::OFS_MAIN_CONTROL_TWO:
                    cfg_nxt.main_control_two = wr_data_r;
                ccrb_pkg::OFS_OUTPUT_CURRENT_LIMIT:
                    // Codes above full scale are clipped to 100 percent.
                    cfg_nxt.output_current_limit =
                        (wr_data_r[6:0] > ccrb_pkg::MAX_OUTPUT_CURRENT_LIMIT
                         || wr_data_r[7])
                        ? ccrb_pkg::MAX_OUTPUT_CURRENT_LIMIT
                        : wr_data_r[6:0];
                ccrb_pkg::OFS_INPUT_UNDERVOLTAGE_LEVEL:
                    cfg_nxt.input_undervoltage_level = wr_data_r;
                ccrb_pkg::OFS_SWITCHING_FREQUENCY:
                    cfg_nxt.switching_frequency = wr_data_r;
                ccrb_pkg::OFS_INTERRUPT_MASK_ONE:
                    cfg_nxt.interrupt_mask_one = wr_data_r;
                ccrb_pkg::OFS_INTERRUPT_MASK_TWO:
                    cfg_nxt.interrupt_mask_two = wr_data_r;
                ccrb_pkg::OFS_FAULT_ONE:
                    if (wr_data_r[ccrb_pkg::BIT_INT_RELEASE]) begin
                        irq_nxt = 1'b0;
                    end
                default: cfg_nxt = cfg_r;
            endcase
        end
        // A fault in the release cycle keeps the line asserted.
        if (fault_event_i || wd_expired) begin
            irq_nxt = 1'b1;
        end
        if (cfg_r.forced_hiz) begin
            ocp_cnt_nxt = 5'h00;
            ocp_off_nxt = 1'b0;
        end else if (switch_cycle_i) begin
            if (current_limit_trip_i) begin
                if (ocp_cnt_r != 5'(OCP_CYCLES)) begin
                    ocp_cnt_nxt = ocp_cnt_r + 5'h01;
                end
                if (ocp_cnt_r + 5'h01 >= 5'(OCP_CYCLES) && !ocp_disable) begin
                    ocp_off_nxt = 1'b1;
                end
            end else begin
                ocp_cnt_nxt = 5'h00;
            end
        end
        // Forced high impedance wins over the pin and the override.
        powered_nxt = !cfg_r.forced_hiz && !ocp_off_r
                      && (en_s2_r || enable_override_i);
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_r <= ccrb_pkg::CFG_DEFAULT;
            kick_r <= 1'b0;
            irq_r <= 1'b0;
            powered_r <= 1'b0;
            ocp_cnt_r <= 5'h00;
            ocp_off_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            kick_r <= kick_nxt;
            irq_r <= irq_nxt;
            powered_r <= powered_nxt;
            ocp_cnt_r <= ocp_cnt_nxt;
            ocp_off_r <= ocp_off_nxt;
        end
    end

    ccrb_watchdog #(
        .TICK_CYCLES(WD_TICK_CYCLES)
    ) u_watchdog (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .period_i(cfg_r.main_control_two[1:0]),
        .hold_i(!powered_r),
        .kick_i(kick_r),
        .expired_o(wd_expired)
    );

    // Open-drain pins only ever pull low.
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_r;
    assign interrupt_out_n_o = 1'b0;
    assign interrupt_out_n_oe_o = irq_r;
    assign cfg_o = cfg_r;
    assign powered_on_o = powered_r;
    assign overcurrent_off_o = ocp_off_r;
    assign watchdog_expired_o = wd_expired;

endmodule // ccrb_top

// ==== ccrb_top_monitor.sv ====
// Port-level assertions for the converter control register bank.
`timescale 1ns/10ps
module ccrb_top_monitor (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic enable_override_i,
    input wire logic interrupt_out_n_oe_o,
    input wire ccrb_pkg::ccrb_cfg_s cfg_o,
    input wire logic powered_on_o,
    input wire logic overcurrent_off_o,
    input wire logic watchdog_expired_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    hiz_forces_off_a: assert property (cfg_o.forced_hiz |=> !powered_on_o)
        else $error("powered on while forced off");
    ocp_forces_off_a: assert property (overcurrent_off_o |=> !powered_on_o)
        else $error("powered on after overcurrent turn-off");
    ocp_disable_a: assert property ($rose(overcurrent_off_o)
        |-> !$past(cfg_o.main_control_two[6])) else $error("shutdown not disabled");
    hiz_wd_idle_a: assert property (cfg_o.forced_hiz [*4]
        |-> !watchdog_expired_o) else $error("watchdog active while off");
    wd_off_idle_a: assert property ((cfg_o.main_control_two[1:0] == 2'h0) [*4]
        |-> !watchdog_expired_o) else $error("watchdog active while disabled");
    wd_expiry_irq_a: assert property ($rose(watchdog_expired_o)
        |-> ##[0:2] interrupt_out_n_oe_o) else $error("expiry raised no interrupt");
    limit_range_a: assert property (cfg_o.output_current_limit <= 7'h64)
        else $error("current limit above full scale");
    override_on_a: assert property ((!cfg_o.forced_hiz && !overcurrent_off_o
        && enable_override_i) [*2] |=> powered_on_o) else $error("override ignored");
    cover property ($rose(overcurrent_off_o));
    cover property ($rose(watchdog_expired_o));
    cover property ($fell(powered_on_o));
endmodule // ccrb_top_monitor

bind ccrb_top ccrb_top_monitor ccrb_top_monitor_inst (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .enable_override_i(enable_override_i),
    .interrupt_out_n_oe_o(interrupt_out_n_oe_o), .cfg_o(cfg_o),
    .powered_on_o(powered_on_o), .overcurrent_off_o(overcurrent_off_o),
    .watchdog_expired_o(watchdog_expired_o));

// ==== ccrb_watchdog.sv ====
// Host watchdog: one-second prescaler and a seconds count with expiry flag.
`timescale 1ns/10ps
module ccrb_watchdog #(
    parameter int TICK_CYCLES = ccrb_pkg::WD_TICK_CYCLES
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] period_i,
    input wire logic hold_i,
    input wire logic kick_i,
    output logic expired_o
);
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic [8:0] sec_cnt_r, sec_cnt_nxt;
    logic expired_r, expired_nxt;
    logic [8:0] limit;

    always_comb begin
        case (period_i)
            2'h1: limit = ccrb_pkg::WD_SEC_80;
            2'h2: limit = ccrb_pkg::WD_SEC_160;
            2'h3: limit = ccrb_pkg::WD_SEC_320;
            default: limit = 9'h000;
        endcase
    end

    always_comb begin
        tick_cnt_nxt = tick_cnt_r;
        sec_cnt_nxt = sec_cnt_r;
        expired_nxt = expired_r;
        if (hold_i || period_i == 2'h0) begin
            // High impedance or disabled period clears the count.
            tick_cnt_nxt = 32'h0;
            sec_cnt_nxt = 9'h000;
            expired_nxt = 1'b0;
        end else if (kick_i) begin
            tick_cnt_nxt = 32'h0;
            sec_cnt_nxt = 9'h000;
            expired_nxt = 1'b0;
        end else if (!expired_r) begin
            if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
                tick_cnt_nxt = 32'h0;
                sec_cnt_nxt = sec_cnt_r + 9'h001;
                if (sec_cnt_r + 9'h001 >= limit) begin
                    expired_nxt = 1'b1;
                end
            end else begin
                tick_cnt_nxt = tick_cnt_r + 32'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt_r <= 32'h0;
            sec_cnt_r <= 9'h000;
            expired_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            sec_cnt_r <= sec_cnt_nxt;
            expired_r <= expired_nxt;
        end
    end

    assign expired_o = expired_r;

endmodule // ccrb_watchdog

// ==== test_converter_control_register_bank.sv ====
// Self-checking bench for the converter control register bank.
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_converter_control_register_bank;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic en = 1'b0, ovr = 1'b0, swc = 1'b0, trip = 1'b0, therm = 1'b0;
    logic scl, sda, sda_oe, rd_done, int_oe, pwr, ocp, wd, flt = 1'b0;
    logic [7:0] cstat = 8'h00, rdd, v, r;
    logic [7:0] exp_q[$];
    ccrb_pkg::ccrb_cfg_s cfg;
    int err_count = 0;
    int check_count = 0;
    always #25 mclk_i = ~mclk_i;
    ccrb_top #(.WD_TICK_CYCLES(10), .OCP_CYCLES(8)) ccrb_top_inst (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(sda_oe), .enable_pin_i(en),
        .enable_override_i(ovr), .interrupt_line_i(~int_oe),
        .interrupt_out_n_o(), .interrupt_out_n_oe_o(int_oe),
        .fault_event_i(flt), .switch_cycle_i(swc),
        .current_limit_trip_i(trip), .thermal_active_i(therm),
        .output_converter_status_i(cstat), .cfg_o(cfg), .powered_on_o(pwr),
        .overcurrent_off_o(ocp), .watchdog_expired_o(wd));
    ccrb_host ccrb_host_inst (.mclk_i(mclk_i), .sda_oe_i(sda_oe),
        .scl_o(scl), .sda_o(sda), .rd_data_o(rdd), .rd_done_o(rd_done));
    always @(posedge mclk_i) begin
        if (rd_done === 1'b1) begin
            v = exp_q.pop_front();
            `CHK("read", v, rdd)
        end
    end
    task automatic rc(input logic [7:0] ofs, input logic [7:0] e);
        exp_q.push_back(e);
        ccrb_host_inst.rd(ofs);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            swc = 1'b1;
            cyc(1);
            swc = 1'b0;
            cyc(1);
        end
        cyc(2);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        void'($urandom(32'habd7));
        cyc(5);
        reset_n_i = 1'b1;
        cyc(2);
        `CHK("cfg", ccrb_pkg::CFG_DEFAULT, cfg)
        rc(8'h01, 8'hb4);
        ccrb_host_inst.wr(8'h17, 8'h7f);
        rc(8'h17, 8'h64);
        r = 8'($urandom_range(100));
        ccrb_host_inst.wr(8'h17, r);
        rc(8'h17, r);
        r = 8'($urandom);
        ccrb_host_inst.wr(8'h1a, r);
        rc(8'h1a, r);
        therm = 1'b1;
        en = 1'b1;
        cstat = 8'($urandom);
        ccrb_host_inst.wr(8'h02, 8'h00);
        ccrb_host_inst.wr(8'h18, 8'h00);
        rc(8'h02, 8'h62);
        rc(8'h18, 8'h64);
        rc(8'h03, 8'h40);
        rc(8'h20, cstat);
        rc(8'h40, 8'h00);
        ccrb_host_inst.wr(8'h00, 8'h80);
        rc(8'h02, 8'h60);
        `CHK("hiz", 1'b0, pwr)
        en = 1'b0;
        ovr = 1'b1;
        ccrb_host_inst.wr(8'h00, 8'h02);
        rc(8'h00, 8'h02);
        `CHK("override", 1'b1, pwr)
        // The eighth tripped cycle turns off, not the seventh.
        ccrb_host_inst.wr(8'h01, 8'h00);
        trip = 1'b1;
        pulses(7);
        `CHK("ocp7", 1'b0, ocp)
        pulses(1);
        `CHK("ocp8", 1'b1, ocp)
        `CHK("ocp_pwr", 1'b0, pwr)
        ccrb_host_inst.wr(8'h01, 8'h40);
        ccrb_host_inst.wr(8'h00, 8'h80);
        ccrb_host_inst.wr(8'h00, 8'h02);
        pulses(9);
        `CHK("ocp_dis", 1'b0, ocp)
        trip = 1'b0;
        // Watchdog at 80 ticks of 10 cycles: a kick restarts the count.
        ccrb_host_inst.wr(8'h01, 8'h01);
        ccrb_host_inst.wr(8'h00, 8'h06);
        cyc(700);
        `CHK("wd_early", 1'b0, wd)
        for (int i = 0; i < 200 && wd !== 1'b1; i++) cyc(1);
        `CHK("wd_late", 1'b1, wd)
        if (wd !== 1'b1) results();
        cyc(2);
        `CHK("wd_irq", 1'b1, int_oe)
        ccrb_host_inst.wr(8'h01, 8'h00);
        `CHK("wd_off", 1'b0, wd)
        rc(8'h02, 8'h02);
        rc(8'h00, 8'h02);
        ccrb_host_inst.wr(8'h05, 8'h80);
        `CHK("release", 1'b0, int_oe)
        rc(8'h02, 8'h42);
        ccrb_host_inst.wr(8'h00, 8'h81);
        `CHK("restore", ccrb_pkg::CFG_DEFAULT, cfg)
        rc(8'h00, 8'h00);
        flt = 1'b1;
        cyc(1);
        flt = 1'b0;
        ccrb_host_inst.wr(8'h01, 8'h02);
        cyc(1300);
        `CHK("wd160", 1'b0, wd)
        `CHK("fault", 1'b1, int_oe)
        results();
    end
endmodule // test_converter_control_register_bank
